/* File: hw/vowc_map.svh */
// Register offsets, field positions and reset values of the overlay window control block.
`ifndef VOWC_MAP_SVH
`define VOWC_MAP_SVH
`define VOWC_CTRL_OFFSET       8'h00
`define VOWC_W1_SRC_OFFSET     8'h04
`define VOWC_CAP1_OFFSET       8'h08
`define VOWC_CAP2_OFFSET       8'h0c
`define VOWC_STATUS_OFFSET     8'h10
`define VOWC_CTRL_RESET        32'h0000_0000
`define VOWC_ADDR_RESET        19'h0_0000
`define VOWC_BIT_FETCH         25
`define VOWC_BIT_LINKED        24
`define VOWC_BIT_FIXED_INTERP  23
`define VOWC_BIT_FLICKER       22
`define VOWC_BIT_VINTERP       21
`define VOWC_BIT_W1_KEY        20
`define VOWC_BIT_TOP_SEL       19
`define VOWC_GFX_MSB           18
`define VOWC_GFX_LSB           16
`define VOWC_BIT_W2_DOUBLE     14
`define VOWC_BIT_W2_REPL       13
`define VOWC_BIT_W2_AVG        12
`define VOWC_BIT_W2_EN         11
`define VOWC_W2_FMT_MSB        10
`define VOWC_W2_FMT_LSB        8
`define VOWC_BIT_W1_DOUBLE     6
`define VOWC_BIT_W1_REPL       5
`define VOWC_BIT_W1_AVG        4
`define VOWC_BIT_W1_EN         3
`define VOWC_W1_FMT_MSB        2
`define VOWC_W1_FMT_LSB        0
`define VOWC_FIXED_SCALE       8'h50
`define VOWC_ADDR_W            19
`define VOWC_SHIFT_DIV         2
`endif

/* File: hw/vowc_pkg.sv */
// Types shared by the overlay window control block.
package vowc_pkg;
  typedef enum logic [2:0] {
    VOWC_FMT_IDX8   = 3'h0,
    VOWC_FMT_RGB555 = 3'h1,
    VOWC_FMT_RGB565 = 3'h2,
    VOWC_FMT_XRGB   = 3'h3,
    VOWC_FMT_RGB888 = 3'h4,
    VOWC_FMT_RGB332 = 3'h5,
    VOWC_FMT_YUV422 = 3'h6
  } vowc_fmt_t;

  typedef struct packed {
    logic      display_en;
    vowc_fmt_t pixel_format;
    logic      yuv_avg_en;
    logic      replicate_en;
    logic      doubling_en;
    logic      queue_shift;
  } vowc_win_t;
endpackage : vowc_pkg

/* File: hw/vowc_ctrl.sv */
// Overlay window control register and its decoded controls.
// Operation
// RULE1: Fetch bit routes 8-bit index data to panel through video queue zero.
// RULE2: Linked bit clear takes window 1 address from its own register.
// RULE3: Linked bit set with single capture buffer uses capture buffer 1.
// RULE4: Double buffer capture displays whichever buffer is not being written.
// RULE5: Fixed interpolation bit forces vertical interpolation with scale eighty.
// RULE6: Flicker bit uses video queue one; software enables one window only.
// RULE7: Vertical interpolation bit: 0 duplicates lines, 1 interpolates; single window only.
// RULE8: Bit 20 enables colour keying for window 1.
// RULE9: Bit 19 selects window on top: 0 window 1, 1 window 2.
// RULE10: Bits 18:16 select graphics pixel format, codes 000 to 101.
// RULE11: Window 2 doubling shifts video queue one every two pixel clocks.
// RULE12: Bit 13 selects window 2 interpolation at 0, duplication at 1.
// RULE13: Bit 12 averages pairs of window 2 YUV pixels.
// RULE14: Bit 11 enables window 2 display.
// RULE15: Bits 10:8 select window 2 format; 11x means YUV 4:2:2.
// RULE16: Window 1 doubling shifts video queue zero every two pixel clocks.
// RULE17: Bit 5 selects window 1 interpolation at 0, duplication at 1.
// RULE18: Bit 4 averages pairs of window 1 YUV pixels.
// RULE19: Bit 3 enables window 1 display.
// RULE20: Bits 2:0 select window 1 format; 11x means YUV 4:2:2.
// RULE21: Software avoids graphics codes 11x and treats bits 15, 7 reserved.
`timescale 1ns/1ps
`default_nettype none
`include "vowc_map.svh"
module vowc_ctrl
  import vowc_pkg::*;
#(
  parameter int ADDR_W = `VOWC_ADDR_W
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  input  wire logic              cap_double_i,
  input  wire logic              cap_buf1_busy_i,
  input  wire logic              pixel_tick_i,
  output logic                   tv_index_fetch_en_o,
  output logic                   index_via_queue_zero_o,
  output logic      [ADDR_W-1:0] window1_src_addr_o,
  output logic                   vinterp_active_o,
  output logic      [7:0]        vscale_o,
  output logic                   fixed_scale_o,
  output logic                   interlace_flicker_en_o,
  output logic                   queue_one_flicker_o,
  output logic                   window1_key_en_o,
  output logic                   top_window_sel_o,
  output vowc_fmt_t              graphics_pixel_format_o,
  output logic                   graphics_fmt_bad_o,
  output vowc_win_t              window1_o,
  output vowc_win_t              window2_o,
  output logic                   config_conflict_o
);

  logic [31:0]       ctrl_reg,  ctrl_next;
  logic [ADDR_W-1:0] src_reg,   src_next;
  logic [ADDR_W-1:0] cap1_reg,  cap1_next;
  logic [ADDR_W-1:0] cap2_reg,  cap2_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              phase_reg, phase_next;
  logic [ADDR_W-1:0] w1_addr_reg, w1_addr_next;
  logic              both_win;
  logic              ctrl_wr;

  // Register writes and the one-cycle-late read answer.
  always_comb begin
    ctrl_next  = ctrl_reg;
    src_next   = src_reg;
    cap1_next  = cap1_reg;
    cap2_next  = cap2_reg;
    rdata_next = 32'h0000_0000;
    if (wr_i) begin
      unique case (addr_i)
        `VOWC_CTRL_OFFSET: begin
          ctrl_next = {6'h00, wdata_i[25:0]};
        end
        `VOWC_W1_SRC_OFFSET: begin
          src_next = wdata_i[ADDR_W-1:0];
        end
        `VOWC_CAP1_OFFSET: begin
          cap1_next = wdata_i[ADDR_W-1:0];
        end
        `VOWC_CAP2_OFFSET: begin
          cap2_next = wdata_i[ADDR_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `VOWC_CTRL_OFFSET:   rdata_next = ctrl_reg;
        `VOWC_W1_SRC_OFFSET: rdata_next = 32'(src_reg);
        `VOWC_CAP1_OFFSET:   rdata_next = 32'(cap1_reg);
        `VOWC_CAP2_OFFSET:   rdata_next = 32'(cap2_reg);
        `VOWC_STATUS_OFFSET: rdata_next = {29'h0000_0000, config_conflict_o,
                                           phase_reg, graphics_fmt_bad_o};
        default:             rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg  <= `VOWC_CTRL_RESET;
      src_reg   <= `VOWC_ADDR_RESET;
      cap1_reg  <= `VOWC_ADDR_RESET;
      cap2_reg  <= `VOWC_ADDR_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg  <= ctrl_next;
      src_reg   <= src_next;
      cap1_reg  <= cap1_next;
      cap2_reg  <= cap2_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // Shift phase and window 1 source address selection.
  always_comb begin
    phase_next = phase_reg;
    if (pixel_tick_i) begin
      phase_next = ~phase_reg;
    end
    // RULE2 own address register
    w1_addr_next = src_reg;
    if (ctrl_reg[`VOWC_BIT_LINKED]) begin
      // RULE3 single capture buffer
      w1_addr_next = cap1_reg;
      // RULE4 idle buffer shown
      if (cap_double_i && cap_buf1_busy_i) begin
        w1_addr_next = cap2_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg   <= 1'b0;
      w1_addr_reg <= `VOWC_ADDR_RESET;
    end else begin
      phase_reg   <= phase_next;
      w1_addr_reg <= w1_addr_next;
    end
  end

  assign window1_src_addr_o = w1_addr_reg;

  // RULE1 index fetch routing
  assign tv_index_fetch_en_o    = ctrl_reg[`VOWC_BIT_FETCH];
  assign index_via_queue_zero_o = ctrl_reg[`VOWC_BIT_FETCH]
                                  && (graphics_pixel_format_o == VOWC_FMT_IDX8);
  // RULE5 fixed scale eighty
  assign fixed_scale_o    = ctrl_reg[`VOWC_BIT_FIXED_INTERP];
  assign vscale_o         = `VOWC_FIXED_SCALE;
  // RULE7 interpolate or duplicate
  assign vinterp_active_o = ctrl_reg[`VOWC_BIT_VINTERP] | ctrl_reg[`VOWC_BIT_FIXED_INTERP];
  // RULE6 queue one flicker use
  assign interlace_flicker_en_o = ctrl_reg[`VOWC_BIT_FLICKER];
  assign queue_one_flicker_o    = ctrl_reg[`VOWC_BIT_FLICKER];
  // RULE8 window 1 keying
  assign window1_key_en_o = ctrl_reg[`VOWC_BIT_W1_KEY];
  // RULE9 top window
  assign top_window_sel_o = ctrl_reg[`VOWC_BIT_TOP_SEL];
  // RULE10 graphics format
  assign graphics_pixel_format_o = vowc_fmt_t'(ctrl_reg[`VOWC_GFX_MSB:`VOWC_GFX_LSB]);
  // RULE21 reserved code flagged
  assign graphics_fmt_bad_o = ctrl_reg[`VOWC_GFX_MSB] & ctrl_reg[`VOWC_GFX_MSB-1];

  // Both windows on while a single-window feature is set is reported, not corrected.
  assign both_win = ctrl_reg[`VOWC_BIT_W1_EN] & ctrl_reg[`VOWC_BIT_W2_EN];
  // RULE6 single window check
  assign config_conflict_o = both_win
                             & (ctrl_reg[`VOWC_BIT_FLICKER] | ctrl_reg[`VOWC_BIT_VINTERP]);

  // One decoder per window; window 2 fields sit eight bits above those of window 1.
  vowc_win_t win_dec [2];

  for (genvar w = 0; w < 2; w++) begin : g_win
    localparam int FMT_MSB  = (w == 0) ? `VOWC_W1_FMT_MSB : `VOWC_W2_FMT_MSB;
    localparam int FMT_LSB  = (w == 0) ? `VOWC_W1_FMT_LSB : `VOWC_W2_FMT_LSB;
    localparam int EN_BIT   = (w == 0) ? `VOWC_BIT_W1_EN : `VOWC_BIT_W2_EN;
    localparam int AVG_BIT  = (w == 0) ? `VOWC_BIT_W1_AVG : `VOWC_BIT_W2_AVG;
    localparam int REPL_BIT = (w == 0) ? `VOWC_BIT_W1_REPL : `VOWC_BIT_W2_REPL;
    localparam int DBL_BIT  = (w == 0) ? `VOWC_BIT_W1_DOUBLE : `VOWC_BIT_W2_DOUBLE;
    logic [2:0] fmt_code;
    vowc_fmt_t  fmt_shown;
    assign fmt_code = ctrl_reg[FMT_MSB:FMT_LSB];
    // RULE15 RULE20 11x is YUV
    assign fmt_shown = (fmt_code[2:1] == 2'h3) ? VOWC_FMT_YUV422 : vowc_fmt_t'(fmt_code);
    // RULE14 RULE19 window enable
    assign win_dec[w].display_en   = ctrl_reg[EN_BIT];
    assign win_dec[w].pixel_format = fmt_shown;
    // RULE13 RULE18 YUV averaging
    assign win_dec[w].yuv_avg_en   = ctrl_reg[AVG_BIT];
    // RULE12 RULE17 replication select
    assign win_dec[w].replicate_en = ctrl_reg[REPL_BIT];
    assign win_dec[w].doubling_en  = ctrl_reg[DBL_BIT];
    // RULE11 RULE16 every second tick
    assign win_dec[w].queue_shift  = pixel_tick_i & (~ctrl_reg[DBL_BIT] | phase_reg);
  end : g_win

  assign window1_o = win_dec[0];
  assign window2_o = win_dec[1];

  // Control word writes, as the assertions below see them.
  assign ctrl_wr = wr_i && (addr_i == `VOWC_CTRL_OFFSET);

  // RULE2 own register selected
  a_own_addr_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE2
    !ctrl_reg[`VOWC_BIT_LINKED] |=> window1_src_addr_o == $past(src_reg))
    else $error("window 1 address not from own register");

  // RULE3 single buffer address
  a_cap1_addr_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE3
    ctrl_reg[`VOWC_BIT_LINKED] && !cap_double_i |=> window1_src_addr_o == $past(cap1_reg))
    else $error("window 1 address not capture buffer 1");

  // RULE4 idle buffer address
  a_cap2_addr_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE4
    ctrl_reg[`VOWC_BIT_LINKED] && cap_double_i && cap_buf1_busy_i
    |=> window1_src_addr_o == $past(cap2_reg))
    else $error("window 1 address not the idle buffer");

  // RULE16 half rate shift
  a_w1_half_rate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE16
    window1_o.doubling_en && window1_o.queue_shift |=> !window1_o.queue_shift)
    else $error("queue zero shifted on two pixel ticks in a row");

  // RULE11 half rate shift
  a_w2_half_rate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE11
    window2_o.doubling_en && window2_o.queue_shift |=> !window2_o.queue_shift)
    else $error("queue one shifted on two pixel ticks in a row");

  // RULE5 scale fixed eighty
  a_fixed_scale: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE5
    fixed_scale_o |-> vinterp_active_o && vscale_o == `VOWC_FIXED_SCALE)
    else $error("fixed interpolation scale wrong");

  // RULE14 window 2 enable write
  a_w2_enable_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE14
    wr_i && addr_i == `VOWC_CTRL_OFFSET |=> window2_o.display_en == $past(wdata_i[11]))
    else $error("window 2 enable did not follow write");

  // RULE20 YUV code decode
  a_w1_yuv_fmt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE20
    ctrl_reg[2:1] == 2'h3 |-> window1_o.pixel_format == VOWC_FMT_YUV422)
    else $error("window 1 11x code not YUV");

  // RULE1 queue zero routing
  a_index_route: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE1
    index_via_queue_zero_o |-> tv_index_fetch_en_o && ctrl_reg[18:16] == 3'h0)
    else $error("index routing without fetch bit");

  // RULE1 fetch bit write
  a_fetch_bit_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE1
    ctrl_wr |=> tv_index_fetch_en_o == $past(wdata_i[`VOWC_BIT_FETCH]))
    else $error("index fetch enable did not follow write");

  // RULE5 fixed bit write
  a_fixed_bit_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE5
    ctrl_wr |=> fixed_scale_o == $past(wdata_i[`VOWC_BIT_FIXED_INTERP]))
    else $error("fixed interpolation did not follow write");

  // RULE6 flicker bit write
  a_flicker_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE6
    ctrl_wr |=> queue_one_flicker_o == $past(wdata_i[`VOWC_BIT_FLICKER]))
    else $error("queue one flicker use did not follow write");

  // RULE6 single window flagged
  a_conflict_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE6
    window1_o.display_en && window2_o.display_en && interlace_flicker_en_o
    |-> config_conflict_o)
    else $error("flicker with two windows not flagged");

  // RULE7 interpolation bit write
  a_vinterp_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE7
    ctrl_wr && !wdata_i[`VOWC_BIT_FIXED_INTERP]
    |=> vinterp_active_o == $past(wdata_i[`VOWC_BIT_VINTERP]))
    else $error("vertical interpolation did not follow write");

  // RULE8 key enable write
  a_key_enable_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE8
    ctrl_wr |=> window1_key_en_o == $past(wdata_i[`VOWC_BIT_W1_KEY]))
    else $error("window 1 key enable did not follow write");

  // RULE9 top window write
  a_top_select_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE9
    ctrl_wr |=> top_window_sel_o == $past(wdata_i[`VOWC_BIT_TOP_SEL]))
    else $error("top window select did not follow write");

  // RULE10 graphics format write
  a_gfx_format_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE10
    ctrl_wr |=> graphics_pixel_format_o == $past(wdata_i[`VOWC_GFX_MSB:`VOWC_GFX_LSB]))
    else $error("graphics format did not follow write");

  // RULE12 window 2 replication
  a_w2_repl_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE12
    ctrl_wr |=> window2_o.replicate_en == $past(wdata_i[`VOWC_BIT_W2_REPL]))
    else $error("window 2 replication did not follow write");

  // RULE13 window 2 averaging
  a_w2_avg_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE13
    ctrl_wr |=> window2_o.yuv_avg_en == $past(wdata_i[`VOWC_BIT_W2_AVG]))
    else $error("window 2 averaging did not follow write");

  // RULE15 window 2 YUV
  a_w2_yuv_fmt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE15
    ctrl_wr && wdata_i[`VOWC_W2_FMT_MSB -: 2] == 2'h3
    |=> window2_o.pixel_format == VOWC_FMT_YUV422)
    else $error("window 2 11x code not YUV");

  // RULE17 window 1 replication
  a_w1_repl_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE17
    ctrl_wr |=> window1_o.replicate_en == $past(wdata_i[`VOWC_BIT_W1_REPL]))
    else $error("window 1 replication did not follow write");

  // RULE18 window 1 averaging
  a_w1_avg_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE18
    ctrl_wr |=> window1_o.yuv_avg_en == $past(wdata_i[`VOWC_BIT_W1_AVG]))
    else $error("window 1 averaging did not follow write");

  // RULE19 window 1 enable
  a_w1_enable_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE19
    ctrl_wr |=> window1_o.display_en == $past(wdata_i[`VOWC_BIT_W1_EN]))
    else $error("window 1 enable did not follow write");

  // RULE20 window 1 format
  a_w1_format_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE20
    ctrl_wr && wdata_i[`VOWC_W1_FMT_MSB -: 2] != 2'h3
    |=> window1_o.pixel_format == $past(wdata_i[`VOWC_W1_FMT_MSB:`VOWC_W1_FMT_LSB]))
    else $error("window 1 format did not follow write");

  // RULE21 reserved code flag
  a_fmt_bad_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // RULE21
    ctrl_wr && wdata_i[`VOWC_GFX_MSB -: 2] == 2'h3 |=> graphics_fmt_bad_o)
    else $error("reserved graphics code not flagged");

  // Main scenarios: linked double buffer, half rate, conflict, YUV window, index routing.
  c_linked_double: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ctrl_reg[`VOWC_BIT_LINKED] && cap_double_i && cap_buf1_busy_i);
  c_w1_doubling: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    window1_o.doubling_en && window1_o.queue_shift);
  c_conflict: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    config_conflict_o);
  c_w2_yuv_avg: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    window2_o.pixel_format == VOWC_FMT_YUV422 && window2_o.yuv_avg_en);
  c_index_route: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    index_via_queue_zero_o);

endmodule : vowc_ctrl
`default_nettype wire

/* File: tb/vowc_ctrl_tb.sv */
// Self-checking testbench for the overlay window control block.
`timescale 1ns/1ps
`default_nettype none
`include "vowc_map.svh"
module vowc_ctrl_tb;
  import vowc_pkg::*;
  logic        clk_sys_i, rst_n_i, wr_i, rd_i, cap_double_i, cap_buf1_busy_i, pixel_tick_i;
  logic [7:0]  addr_i, vscale_o;
  logic [31:0] wdata_i, rdata_o, d;
  logic [18:0] window1_src_addr_o;
  logic        tv_index_fetch_en_o, index_via_queue_zero_o, vinterp_active_o, fixed_scale_o;
  logic        interlace_flicker_en_o, queue_one_flicker_o, window1_key_en_o, top_window_sel_o;
  logic        graphics_fmt_bad_o, config_conflict_o;
  vowc_fmt_t   graphics_pixel_format_o;
  vowc_win_t   window1_o, window2_o;
  logic [2:0]  b, f, g;
  logic [7:0]  w1, w2;
  int          bad_count, n_checks;

  vowc_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_double_i(cap_double_i),
    .cap_buf1_busy_i(cap_buf1_busy_i), .pixel_tick_i(pixel_tick_i),
    .tv_index_fetch_en_o(tv_index_fetch_en_o), .index_via_queue_zero_o(index_via_queue_zero_o),
    .window1_src_addr_o(window1_src_addr_o), .vinterp_active_o(vinterp_active_o),
    .vscale_o(vscale_o), .fixed_scale_o(fixed_scale_o),
    .interlace_flicker_en_o(interlace_flicker_en_o), .queue_one_flicker_o(queue_one_flicker_o),
    .window1_key_en_o(window1_key_en_o), .top_window_sel_o(top_window_sel_o),
    .graphics_pixel_format_o(graphics_pixel_format_o), .graphics_fmt_bad_o(graphics_fmt_bad_o),
    .window1_o(window1_o), .window2_o(window2_o), .config_conflict_o(config_conflict_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(rdata_o, exp, "read data");
  endtask : rd

  // The capture inputs are levels and the chosen address is registered once, so it settles fast.
  task automatic src(input logic dbl, input logic busy, input logic [18:0] exp);
    @(posedge clk_sys_i);
    cap_double_i    <= dbl;
    cap_buf1_busy_i <= busy;
    repeat (3) @(negedge clk_sys_i);
    chk(32'(window1_src_addr_o), 32'(exp), "window source address");
  endtask : src

  task automatic shifts(input int exp1, input int exp2);
    int c1;
    int c2;
    c1 = 0;
    c2 = 0;
    @(posedge clk_sys_i);
    pixel_tick_i <= 1'b1;
    repeat (4) begin
      @(negedge clk_sys_i);
      c1 += int'(window1_o.queue_shift);
      c2 += int'(window2_o.queue_shift);
      @(posedge clk_sys_i);
    end
    pixel_tick_i <= 1'b0;
    chk(32'(c1), 32'(exp1), "queue zero shifts");
    chk(32'(c2), 32'(exp2), "queue one shifts");
  endtask : shifts

  initial begin
    {rst_n_i, wr_i, rd_i, cap_double_i, cap_buf1_busy_i, pixel_tick_i} = '0;
    addr_i    = 8'h00;
    wdata_i   = 32'h0000_0000;
    bad_count = 0;
    n_checks  = 0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(`VOWC_CTRL_OFFSET, `VOWC_CTRL_RESET);
    chk(32'(vscale_o), 32'(`VOWC_FIXED_SCALE), "scale");
    chk(32'(window1_src_addr_o), 32'(`VOWC_ADDR_RESET), "reset address");
    // Eight field patterns, every window format code with 11x included, graphics codes 000 to 101.
    for (int i = 0; i < 8; i++) begin
      b  = 3'(i);
      f  = (b[2:1] == 2'b11) ? 3'h6 : b;
      g  = 3'(i % 6);
      w1 = {b[0], f, b[1], b[2], b[0] ^ b[1], 1'b0};
      w2 = {b[1], f, b[2], b[0], b[2], 1'b0};
      d  = {8'h00, b[1] & b[2], b[0] & b[2], b[2], b[0], b[1], g, 1'b0,
            w2[1], w2[2], w2[3], w2[7], b, 1'b0, w1[1], w1[2], w1[3], w1[7], b};
      wr(`VOWC_CTRL_OFFSET, d);
      chk(32'(window1_o), 32'(w1), "window 1");
      chk(32'(window2_o), 32'(w2), "window 2");
      chk(32'(graphics_pixel_format_o), 32'(g), "graphics format");
      chk(32'({window1_key_en_o, top_window_sel_o}), 32'({b[0], b[1]}),
          "key and top");
      chk(32'({vinterp_active_o, fixed_scale_o, interlace_flicker_en_o, queue_one_flicker_o}),
          32'({b[2], b[1] & b[2], b[0] & b[2], b[0] & b[2]}),
          "interp and flicker");
      chk(32'(config_conflict_o), 32'(b[0] & b[1] & b[2]), "conflict");
      rd(`VOWC_CTRL_OFFSET, d);
    end
    // Both windows on with flicker and interpolation: only the conflict bit of status is set.
    rd(`VOWC_STATUS_OFFSET, 32'h0000_0004);
    wr(`VOWC_CTRL_OFFSET, 32'h0086_0000);
    chk(32'({vinterp_active_o, graphics_fmt_bad_o}), 32'h3,
        "fixed interp, bad code");
    rd(`VOWC_STATUS_OFFSET, 32'h0000_0001);
    wr(`VOWC_CTRL_OFFSET, 32'h0200_0000);
    chk(32'({tv_index_fetch_en_o, index_via_queue_zero_o}), 32'h3, "index fetch");
    wr(`VOWC_CTRL_OFFSET, 32'h0201_0000);
    chk(32'({tv_index_fetch_en_o, index_via_queue_zero_o}), 32'h2, "non index fetch");
    wr(`VOWC_W1_SRC_OFFSET, 32'h0001_2345);
    wr(`VOWC_CAP1_OFFSET, 32'h0000_abcd);
    wr(`VOWC_CAP2_OFFSET, 32'h0005_5555);
    rd(`VOWC_W1_SRC_OFFSET, 32'h0001_2345);
    rd(`VOWC_CAP2_OFFSET, 32'h0005_5555);
    wr(`VOWC_CTRL_OFFSET, 32'h0000_0000);
    src(1'b1, 1'b1, 19'h1_2345);
    wr(`VOWC_CTRL_OFFSET, 32'h0100_0000);
    src(1'b0, 1'b1, 19'h0_abcd);
    src(1'b1, 1'b1, 19'h5_5555);
    src(1'b1, 1'b0, 19'h0_abcd);
    wr(`VOWC_CTRL_OFFSET, 32'h0000_0040);
    shifts(4 / `VOWC_SHIFT_DIV, 4);
    wr(`VOWC_CTRL_OFFSET, 32'h0000_4000);
    shifts(4, 4 / `VOWC_SHIFT_DIV);
    // Unmapped writes must not alias onto the control word.
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0000_0000);
    rd(`VOWC_CTRL_OFFSET, 32'h0000_4000);
    wr(`VOWC_CTRL_OFFSET, 32'hfc00_0000);
    rd(`VOWC_CTRL_OFFSET, 32'h0000_0000);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    $display("mismatch at %0t: run did not finish", $time);
    finish_test();
  end
endmodule : vowc_ctrl_tb
`default_nettype wire
